// ===== rtl/isf_status_flags.sv
// Purpose : Status, buffer and event flag logic of an I2C host/client module
// Assumes : Shift engine runs on clk and hands over one-cycle event pulses
// Notes   : Read data stand only in the cycle after a read strobe
//
// Local design decision: the strobed register port.

`timescale 1ns/1ps

module isf_status_flags (
  input  wire logic               clk,
  input  wire logic               nrst,
  input  wire isf_pkg::isf_addr_t addr,
  input  wire isf_pkg::isf_byte_t wr_data,
  input  wire logic               wr_en,
  input  wire logic               rd_en,
  output      isf_pkg::isf_byte_t rd_data,
  input  wire logic               eng_addr_match,
  input  wire logic               eng_addr_rw,
  input  wire logic               eng_addr_10b_high,
  input  wire logic               eng_data_rx,
  input  wire isf_pkg::isf_byte_t eng_rx_byte,
  input  wire logic               eng_byte_done,
  input  wire logic               eng_byte_is_data,
  input  wire logic               eng_tx_take,
  input  wire logic               eng_fall9,
  input  wire logic               eng_addressed,
  input  wire logic               eng_ack_sent,
  input  wire logic               eng_count_zero,
  input  wire logic               eng_start,
  input  wire logic               eng_restart,
  input  wire logic               eng_stop,
  output      isf_pkg::isf_byte_t tx_data,
  output      logic               nack_request,
  output      logic               dma_tx_req,
  output      logic               dma_rx_req,
  output      logic               rx_irq_flag,
  output      logic               tx_irq_flag,
  output      logic               module_irq,
  output      logic               clock_stretch
);
  import isf_pkg::*;

  // ******************************************************************
  // Decoding helpers
  // ******************************************************************
  function automatic logic hit(input isf_addr_t a, input isf_addr_t r);
    return a == r;
  endfunction

  // Client-capable mode codes are 0xx and 11x
  function automatic logic client_capable(input logic [2:0] m);
    return (m[2] == 1'b0) || (m[2:1] == 2'b11);
  endfunction

  // ******************************************************************
  // State
  // ******************************************************************
  logic       dir_reg;
  logic       kind_reg;
  logic       tx_overwrite_error_reg;
  logic       tx_buffer_empty_reg;
  logic       rx_underread_error_reg;
  logic       rx_buffer_full_reg;
  isf_byte_t  rx_buf_reg;
  isf_byte_t  tx_buf_reg;
  isf_byte_t  flags_reg;
  isf_byte_t  en_reg;
  logic [2:0] mode_reg;
  logic       clock_stretch_reg;
  logic       hi10_pend_reg;
  logic       rx_irq_reg;
  logic       tx_irq_reg;
  logic       nack_reg;
  logic       irq_reg;
  isf_byte_t  rd_data_reg;

  logic       wr_txb;
  logic       wr_ctrl;
  logic       wr_bs;
  logic       wr_ev;
  logic       wr_en_reg_sel;
  logic       rd_rxb;
  logic       flush;
  logic       client;
  logic       ackt_set;
  logic       wr_set;
  logic       adr_set;
  logic       hold_set;
  isf_byte_t  hw_set;
  isf_byte_t  flags_next;
  isf_byte_t  rd_mux;

  assign wr_txb        = wr_en & hit(addr, ISF_ADDR_TX_BUF);
  assign wr_ctrl       = wr_en & hit(addr, ISF_ADDR_CTRL);
  assign wr_bs         = wr_en & hit(addr, ISF_ADDR_BUF_STATUS);
  assign wr_ev         = wr_en & hit(addr, ISF_ADDR_EVT_FLAGS);
  assign wr_en_reg_sel = wr_en & hit(addr, ISF_ADDR_EVT_EN);
  assign rd_rxb        = rd_en & hit(addr, ISF_ADDR_RX_BUF);
  assign client        = client_capable(mode_reg);
  assign flush         = wr_bs & wr_data[ISF_BS_FLUSH_BIT];

  // ******************************************************************
  // Transfer status
  // ******************************************************************
  // Direction capture
  // Only matched received addresses update it
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      dir_reg <= 1'b0;
    end else if (eng_addr_match) begin
      dir_reg <= eng_addr_rw;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      kind_reg <= 1'b0;
    end else if (eng_byte_done) begin
      kind_reg <= eng_byte_is_data;
    end
  end

  // ******************************************************************
  // Receive buffer
  // ******************************************************************
  // Full flag, a new byte wins over a same-cycle read or flush
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rx_buffer_full_reg   <= 1'b0;
      rx_buf_reg <= ISF_BYTE_RST;
    end else if (eng_data_rx) begin
      rx_buffer_full_reg   <= 1'b1;
      rx_buf_reg <= eng_rx_byte;
    end else if (rd_rxb || flush) begin
      rx_buffer_full_reg   <= 1'b0;
    end
  end

  // Underread error, cleared only by a software write of zero
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rx_underread_error_reg <= 1'b0;
    end else begin
      rx_underread_error_reg <= (wr_bs ? wr_data[ISF_BS_RX_UNDERREAD_ERROR_BIT] : rx_underread_error_reg) | (rd_rxb & ~rx_buffer_full_reg);
    end
  end

  // Buffer interrupt flags cleared by flush
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rx_irq_reg <= 1'b0;
    end else if (eng_data_rx) begin
      rx_irq_reg <= 1'b1;
    end else if (rd_rxb || flush) begin
      rx_irq_reg <= 1'b0;
    end
  end

  // ******************************************************************
  // Transmit buffer
  // ******************************************************************
  // Empty flag; a take in the same cycle as a write leaves the new byte
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tx_buffer_empty_reg <= ISF_TX_BUFFER_EMPTY_RST;
    end else if (wr_txb) begin
      tx_buffer_empty_reg <= 1'b0;
    end else if (eng_tx_take || flush) begin
      tx_buffer_empty_reg <= 1'b1;
    end
  end

  // Overwriting a full buffer discards the new byte so the queued one survives
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tx_buf_reg <= ISF_BYTE_RST;
    end else if (wr_txb && (tx_buffer_empty_reg || eng_tx_take)) begin
      tx_buf_reg <= wr_data;
    end
  end

  // Overwrite error, cleared only by a software write of zero
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tx_overwrite_error_reg <= 1'b0;
    end else begin
      tx_overwrite_error_reg <= (wr_bs ? wr_data[ISF_BS_TX_OVERWRITE_ERROR_BIT] : tx_overwrite_error_reg)
                | (wr_txb & ~tx_buffer_empty_reg & ~eng_tx_take);
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tx_irq_reg <= 1'b0;
    end else if (eng_tx_take) begin
      tx_irq_reg <= 1'b1;
    end else if (wr_txb || flush) begin
      tx_irq_reg <= 1'b0;
    end
  end

  // NACK request follows the error bits
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      nack_reg <= 1'b0;
    end else begin
      nack_reg <= tx_overwrite_error_reg | rx_underread_error_reg;
    end
  end

  // ******************************************************************
  // Event flags
  // ******************************************************************
  // A ten-bit high write address byte suppresses the next ack-time flag
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      hi10_pend_reg <= 1'b0;
    end else if (eng_addr_match && eng_addr_10b_high && !eng_addr_rw) begin
      hi10_pend_reg <= 1'b1;
    end else if (eng_fall9) begin
      hi10_pend_reg <= 1'b0;
    end
  end

  assign ackt_set = eng_fall9 & eng_addressed & client & ~hi10_pend_reg;
  assign wr_set   = eng_data_rx & client;
  assign adr_set  = eng_addr_match & client;

  always_comb begin
    hw_set = 8'h00;
    hw_set[ISF_EV_CNT_BIT]     = eng_fall9 & eng_count_zero;
    hw_set[ISF_EV_ACKT_BIT]    = ackt_set;
    hw_set[ISF_EV_WR_BIT]      = wr_set;
    hw_set[ISF_EV_ADR_BIT]     = adr_set;
    hw_set[ISF_EV_STOP_BIT]    = eng_stop;
    hw_set[ISF_EV_RESTART_BIT] = eng_restart;
    hw_set[ISF_EV_START_BIT]   = eng_start;
  end

  // Sticky flags; a hardware set beats a same-cycle clear
  assign flags_next = ((wr_ev ? wr_data : flags_reg) | hw_set) & ISF_EVT_MASK;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      flags_reg <= ISF_FLAGS_RST;
    end else begin
      flags_reg <= flags_next;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      en_reg <= ISF_EN_RST;
    end else if (wr_en_reg_sel) begin
      en_reg <= wr_data & ISF_EVT_MASK;
    end
  end

  // Byte count enable takes part in the OR
  // Stop enable takes part in the OR
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= |(flags_reg & en_reg);
    end
  end

  // ******************************************************************
  // Control and clock stretch
  // ******************************************************************
  // Hold condition on enabled address, write and ack-time events
  // Ack-time hold only after an ACK
  assign hold_set = (ackt_set & en_reg[ISF_EV_ACKT_BIT] & eng_ack_sent)
                  | (wr_set & en_reg[ISF_EV_WR_BIT])
                  | (adr_set & en_reg[ISF_EV_ADR_BIT]);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      mode_reg <= ISF_MODE_RST;
    end else if (wr_ctrl) begin
      mode_reg <= wr_data[ISF_CTRL_MODE_MSB:ISF_CTRL_MODE_LSB];
    end
  end

  // Software releases the bus by writing zero; a new hold in that cycle still wins
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      clock_stretch_reg <= 1'b0;
    end else begin
      clock_stretch_reg <= (wr_ctrl ? wr_data[ISF_CTRL_CLOCK_STRETCH_BIT] : clock_stretch_reg) | hold_set;
    end
  end

  // ******************************************************************
  // Read port
  // ******************************************************************
  always_comb begin
    rd_mux = 8'h00;
    case (addr)
      ISF_ADDR_TX_BUF: begin
        rd_mux = tx_buf_reg;
      end
      ISF_ADDR_RX_BUF: begin
        rd_mux = rx_buf_reg;
      end
      ISF_ADDR_CTRL: begin
        rd_mux[ISF_CTRL_MODE_MSB:ISF_CTRL_MODE_LSB] = mode_reg;
        rd_mux[ISF_CTRL_CLOCK_STRETCH_BIT]                   = clock_stretch_reg;
      end
      ISF_ADDR_XFER_STATUS: begin
        rd_mux[ISF_XS_DIR_BIT]  = dir_reg;
        rd_mux[ISF_XS_KIND_BIT] = kind_reg;
      end
      // Flush bit position stays zero on read
      ISF_ADDR_BUF_STATUS: begin
        rd_mux[ISF_BS_TX_OVERWRITE_ERROR_BIT] = tx_overwrite_error_reg;
        rd_mux[ISF_BS_TX_BUFFER_EMPTY_BIT] = tx_buffer_empty_reg;
        rd_mux[ISF_BS_RX_UNDERREAD_ERROR_BIT] = rx_underread_error_reg;
        rd_mux[ISF_BS_RX_BUFFER_FULL_BIT] = rx_buffer_full_reg;
      end
      ISF_ADDR_EVT_FLAGS: begin
        rd_mux = flags_reg;
      end
      ISF_ADDR_EVT_EN: begin
        rd_mux = en_reg;
      end
      default: begin
        rd_mux = 8'h00;
      end
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rd_data_reg <= ISF_BYTE_RST;
    end else begin
      rd_data_reg <= rd_en ? rd_mux : ISF_BYTE_RST;
    end
  end

  // ******************************************************************
  // Outputs
  // ******************************************************************
  assign rd_data       = rd_data_reg;
  assign tx_data       = tx_buf_reg;
  assign nack_request  = nack_reg;
  assign dma_tx_req    = tx_buffer_empty_reg;
  assign dma_rx_req    = rx_buffer_full_reg;
  assign rx_irq_flag   = rx_irq_reg;
  assign tx_irq_flag   = tx_irq_reg;
  assign module_irq    = irq_reg;
  assign clock_stretch = clock_stretch_reg;

  // ******************************************************************
  // Assertions
  // ******************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  sequence s_flush_quiet;
    flush && !eng_data_rx && !wr_txb && !eng_tx_take;
  endsequence

  sequence s_adr_hold;
    adr_set && en_reg[ISF_EV_ADR_BIT];
  endsequence

  a_dir_capture: assert property (
    eng_addr_match |=> dir_reg == $past(eng_addr_rw))
    else $error("direction bit did not follow matched address");

  a_dir_hold: assert property (
    !eng_addr_match |=> $stable(dir_reg))
    else $error("direction bit changed without a match");

  a_kind_data: assert property (
    eng_byte_done && eng_byte_is_data |=> kind_reg)
    else $error("byte kind not set for data");

  a_tx_overwrite_error_set: assert property (
    wr_txb && !tx_buffer_empty_reg && !eng_tx_take |=> tx_overwrite_error_reg && !tx_buffer_empty_reg)
    else $error("overwrite error missing");

  a_tx_buffer_empty_clear: assert property (
    wr_txb |=> !tx_buffer_empty_reg ##1 (tx_buffer_empty_reg || !$past(eng_tx_take) || $past(wr_txb)))
    else $error("transmit empty not cleared by write");

  a_rx_underread_error_set: assert property (
    rd_rxb && !rx_buffer_full_reg |=> rx_underread_error_reg)
    else $error("underread error missing");

  a_nack_errors: assert property (
    (tx_overwrite_error_reg || rx_underread_error_reg) |=> nack_request)
    else $error("error bit without NACK request");

  a_flush_empty: assert property (
    s_flush_quiet |=> !rx_buffer_full_reg && tx_buffer_empty_reg && !rx_irq_flag && !tx_irq_flag)
    else $error("flush left a buffer or flag set");

  a_flush_read0: assert property (
    rd_en && hit(addr, ISF_ADDR_BUF_STATUS) |=> rd_data[ISF_BS_FLUSH_BIT] == 1'b0)
    else $error("flush bit read nonzero");

  a_rx_buffer_full_read: assert property (
    rd_rxb && !eng_data_rx |=> !dma_rx_req)
    else $error("receive full not cleared by read");

  a_irq_or: assert property (
    ##1 module_irq == |($past(flags_reg) & $past(en_reg)))
    else $error("interrupt request not OR of enabled flags");

  a_adr_stretch: assert property (
    s_adr_hold |=> clock_stretch && flags_reg[ISF_EV_ADR_BIT])
    else $error("address hold did not stretch");

  a_ackt_10b: assert property (
    hi10_pend_reg && eng_fall9 && !wr_ev |=> flags_reg[ISF_EV_ACKT_BIT]
      == $past(flags_reg[ISF_EV_ACKT_BIT]))
    else $error("ack-time flag set after ten-bit high byte");

endmodule

// ===== rtl/isf_pkg.sv
// Purpose : Shared constants and types for the I2C status and event flag block
// Assumes : Registers sit on a plain 12-bit address port with byte-wide data
// Notes   : Offsets are byte addresses on that port

package isf_pkg;

  typedef logic [11:0] isf_addr_t;
  typedef logic [7:0]  isf_byte_t;

  // ******************************************************************
  // Register offsets
  // ******************************************************************
  localparam isf_addr_t ISF_ADDR_TX_BUF      = 12'h290;
  localparam isf_addr_t ISF_ADDR_RX_BUF      = 12'h291;
  localparam isf_addr_t ISF_ADDR_CTRL        = 12'h292;
  localparam isf_addr_t ISF_ADDR_XFER_STATUS = 12'h298;
  localparam isf_addr_t ISF_ADDR_BUF_STATUS  = 12'h299;
  localparam isf_addr_t ISF_ADDR_EVT_FLAGS   = 12'h29A;
  localparam isf_addr_t ISF_ADDR_EVT_EN      = 12'h29B;

  // ******************************************************************
  // Field positions
  // ******************************************************************
  localparam int ISF_XS_DIR_BIT     = 4;
  localparam int ISF_XS_KIND_BIT    = 3;
  localparam int ISF_BS_TX_OVERWRITE_ERROR_BIT    = 7;
  localparam int ISF_BS_TX_BUFFER_EMPTY_BIT    = 5;
  localparam int ISF_BS_RX_UNDERREAD_ERROR_BIT    = 3;
  localparam int ISF_BS_FLUSH_BIT   = 2;
  localparam int ISF_BS_RX_BUFFER_FULL_BIT    = 0;
  localparam int ISF_EV_CNT_BIT     = 7;
  localparam int ISF_EV_ACKT_BIT    = 6;
  localparam int ISF_EV_WR_BIT      = 4;
  localparam int ISF_EV_ADR_BIT     = 3;
  localparam int ISF_EV_STOP_BIT    = 2;
  localparam int ISF_EV_RESTART_BIT = 1;
  localparam int ISF_EV_START_BIT   = 0;
  localparam int ISF_CTRL_MODE_LSB  = 0;
  localparam int ISF_CTRL_MODE_MSB  = 2;
  localparam int ISF_CTRL_CLOCK_STRETCH_BIT  = 4;

  // ******************************************************************
  // Reset values and masks
  // ******************************************************************
  localparam isf_byte_t   ISF_EVT_MASK  = 8'hDF;
  localparam isf_byte_t   ISF_FLAGS_RST = 8'h00;
  localparam isf_byte_t   ISF_EN_RST    = 8'h00;
  localparam isf_byte_t   ISF_BYTE_RST  = 8'h00;
  localparam logic [2:0]  ISF_MODE_RST  = 3'h0;
  localparam logic        ISF_TX_BUFFER_EMPTY_RST  = 1'b1;

endpackage

// ===== sim/isf_engine_model.sv
// Purpose : Shift engine stand-in driving the engine side of the flag block
// Assumes : Shares clk with the block; every pulse lasts one cycle
// Notes   : Qualifiers show the inverse of their last value outside their cycle

`timescale 1ns/1ps

module isf_engine_model (
  input  wire logic   clk,
  output logic        eng_addr_match,
  output logic        eng_addr_rw,
  output logic        eng_addr_10b_high,
  output logic        eng_data_rx,
  output isf_pkg::isf_byte_t eng_rx_byte,
  output logic        eng_byte_done,
  output logic        eng_byte_is_data,
  output logic        eng_tx_take,
  output logic        eng_fall9,
  output logic        eng_addressed,
  output logic        eng_ack_sent,
  output logic        eng_count_zero,
  output logic        eng_start,
  output logic        eng_restart,
  output logic        eng_stop
);
  import isf_pkg::*;

  initial begin
    {eng_addr_match, eng_addr_rw, eng_addr_10b_high, eng_data_rx} = 4'h0;
    {eng_byte_done, eng_byte_is_data, eng_tx_take, eng_fall9} = 4'h0;
    {eng_addressed, eng_ack_sent, eng_count_zero} = 3'h0;
    {eng_start, eng_restart, eng_stop} = 3'h0;
    eng_rx_byte = 8'h00;
  end

  // ****************************************************************
  // Byte and bus events
  // ****************************************************************
  // A non-matching address stands for own host addresses and foreign ones
  task addr_byte(input logic match, input logic rw, input logic high10);
    @(posedge clk);
    eng_addr_match    <= match;
    eng_addr_rw       <= rw;
    eng_addr_10b_high <= high10;
    eng_byte_done     <= 1'b1;
    eng_byte_is_data  <= 1'b0;
    @(posedge clk);
    eng_addr_match    <= 1'b0;
    eng_addr_rw       <= ~rw;
    eng_addr_10b_high <= ~high10;
    eng_byte_done     <= 1'b0;
    eng_byte_is_data  <= 1'b1;
  endtask

  task data_byte(input isf_byte_t b);
    @(posedge clk);
    eng_data_rx      <= 1'b1;
    eng_rx_byte      <= b;
    eng_byte_done    <= 1'b1;
    eng_byte_is_data <= 1'b1;
    @(posedge clk);
    eng_data_rx      <= 1'b0;
    eng_rx_byte      <= ~b;
    eng_byte_done    <= 1'b0;
    eng_byte_is_data <= 1'b0;
  endtask

  task ninth(input logic ack);
    @(posedge clk);
    eng_fall9    <= 1'b1;
    eng_ack_sent <= ack;
    @(posedge clk);
    eng_fall9    <= 1'b0;
    eng_ack_sent <= ~ack;
  endtask

  task cond(input int k);
    @(posedge clk);
    eng_start   <= (k == 0);
    eng_restart <= (k == 1);
    eng_stop    <= (k == 2);
    @(posedge clk);
    {eng_start, eng_restart, eng_stop} <= 3'h0;
  endtask

  task take();
    @(posedge clk);
    eng_tx_take <= 1'b1;
    @(posedge clk);
    eng_tx_take <= 1'b0;
  endtask

  // A byte shifted out; a data byte is taken from the transmit buffer
  task sent(input logic is_data);
    @(posedge clk);
    eng_byte_done    <= 1'b1;
    eng_byte_is_data <= is_data;
    eng_tx_take      <= is_data;
    @(posedge clk);
    eng_byte_done    <= 1'b0;
    eng_byte_is_data <= ~is_data;
    eng_tx_take      <= 1'b0;
  endtask

  task set_lvl(input logic addressed, input logic zero);
    @(posedge clk);
    eng_addressed  <= addressed;
    eng_count_zero <= zero;
  endtask
endmodule

// ===== sim/isf_status_flags_bench.sv
// Purpose : Self-checking bench for the status and event flag block
// Assumes : Register port answers reads in the following cycle
// Notes   : Engine side is played by the engine model through its tasks

`timescale 1ns/1ps

module isf_status_flags_bench;
  import isf_pkg::*;

  logic      clk, nrst, wr_en, rd_en;
  isf_addr_t addr;
  isf_byte_t wr_data, rd_data, tx_data, eng_rx_byte;
  logic      nack_request, dma_tx_req, dma_rx_req, rx_irq_flag, tx_irq_flag;
  logic      module_irq, clock_stretch, eng_addr_match, eng_addr_rw, eng_addr_10b_high;
  logic      eng_data_rx, eng_byte_done, eng_byte_is_data, eng_tx_take, eng_fall9;
  logic      eng_addressed, eng_ack_sent, eng_count_zero, eng_start, eng_restart, eng_stop;
  int        mismatches;
  int        num_checks;

  always #12.5 clk = ~clk;

  isf_status_flags uut (.clk, .nrst, .addr, .wr_data, .wr_en, .rd_en, .rd_data,
    .eng_addr_match, .eng_addr_rw, .eng_addr_10b_high, .eng_data_rx, .eng_rx_byte,
    .eng_byte_done, .eng_byte_is_data, .eng_tx_take, .eng_fall9, .eng_addressed,
    .eng_ack_sent, .eng_count_zero, .eng_start, .eng_restart, .eng_stop, .tx_data,
    .nack_request, .dma_tx_req, .dma_rx_req, .rx_irq_flag, .tx_irq_flag, .module_irq,
    .clock_stretch);

  isf_engine_model eng (.clk, .eng_addr_match, .eng_addr_rw, .eng_addr_10b_high,
    .eng_data_rx, .eng_rx_byte, .eng_byte_done, .eng_byte_is_data, .eng_tx_take,
    .eng_fall9, .eng_addressed, .eng_ack_sent, .eng_count_zero, .eng_start,
    .eng_restart, .eng_stop);

  // ****************************************************************
  // Access and check tasks
  // ****************************************************************
  task chk(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One strobe cycle; the request holds until the edge that takes it
  task access(input logic is_rd, input isf_addr_t a, input isf_byte_t d);
    @(posedge clk);
    addr    <= a;
    wr_data <= d;
    wr_en   <= ~is_rd;
    rd_en   <= is_rd;
    @(posedge clk);
    wr_en   <= 1'b0;
    rd_en   <= 1'b0;
  endtask

  task wr(input isf_addr_t a, input isf_byte_t d);
    access(1'b0, a, d);
  endtask

  // Read data stand only in the cycle after the strobe, so look just past that edge
  task rdc(input isf_addr_t a, input isf_byte_t exp);
    access(1'b1, a, 8'h00);
    #1 chk(rd_data, exp);
  endtask

  task complete_run();
    $display("Checks %0d, mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    complete_run();
  end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    clk = 1'b0;
    nrst = 1'b0;
    {addr, wr_data, wr_en, rd_en} = '0;
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    rdc(ISF_ADDR_BUF_STATUS, 8'h20);
    @(posedge clk);
    #1 chk(rd_data, 8'h00);
    chk(dma_tx_req, 8'h01);
    chk(dma_rx_req, 8'h00);
    rdc(ISF_ADDR_EVT_EN, ISF_EN_RST);
    rdc(ISF_ADDR_RX_BUF, ISF_BYTE_RST);
    rdc(ISF_ADDR_BUF_STATUS, 8'h28);
    chk(nack_request, 8'h01);
    wr(ISF_ADDR_BUF_STATUS, 8'h00);
    rdc(ISF_ADDR_BUF_STATUS, 8'h20);
    chk(nack_request, 8'h00);
    wr(ISF_ADDR_TX_BUF, 8'hA5);
    wr(ISF_ADDR_TX_BUF, 8'h5A);
    rdc(ISF_ADDR_BUF_STATUS, 8'h80);
    chk(tx_data, 8'hA5);
    chk(dma_tx_req, 8'h00);
    eng.take();
    rdc(ISF_ADDR_BUF_STATUS, 8'hA0);
    chk(tx_irq_flag, 8'h01);
    wr(ISF_ADDR_TX_BUF, 8'h3C);
    wr(ISF_ADDR_BUF_STATUS, 8'h04);
    rdc(ISF_ADDR_BUF_STATUS, 8'h20);
    chk(tx_irq_flag, 8'h00);
    eng.data_byte(8'h3C);
    rdc(ISF_ADDR_BUF_STATUS, 8'h21);
    chk(dma_rx_req, 8'h01);
    chk(rx_irq_flag, 8'h01);
    rdc(ISF_ADDR_EVT_FLAGS, 8'h10);
    rdc(ISF_ADDR_XFER_STATUS, 8'h08);
    rdc(ISF_ADDR_RX_BUF, 8'h3C);
    rdc(ISF_ADDR_BUF_STATUS, 8'h20);
    eng.data_byte(8'hC3);
    wr(ISF_ADDR_BUF_STATUS, 8'h04);
    rdc(ISF_ADDR_BUF_STATUS, 8'h20);
    chk(rx_irq_flag, 8'h00);
    wr(ISF_ADDR_EVT_FLAGS, 8'h00);
    wr(ISF_ADDR_EVT_EN, 8'h08);
    eng.addr_byte(1'b1, 1'b1, 1'b0);
    rdc(ISF_ADDR_EVT_FLAGS, 8'h08);
    rdc(ISF_ADDR_XFER_STATUS, 8'h10);
    chk(clock_stretch, 8'h01);
    chk(module_irq, 8'h01);
    eng.addr_byte(1'b0, 1'b0, 1'b0);
    rdc(ISF_ADDR_XFER_STATUS, 8'h10);
    wr(ISF_ADDR_EVT_EN, 8'h10);
    wr(ISF_ADDR_EVT_FLAGS, 8'h00);
    wr(ISF_ADDR_CTRL, 8'h00);
    eng.addr_byte(1'b1, 1'b0, 1'b0);
    rdc(ISF_ADDR_XFER_STATUS, 8'h00);
    chk(clock_stretch, 8'h00);
    chk(module_irq, 8'h00);
    eng.sent(1'b1);
    rdc(ISF_ADDR_XFER_STATUS, 8'h08);
    chk(tx_irq_flag, 8'h01);
    wr(ISF_ADDR_BUF_STATUS, 8'h04);
    rdc(ISF_ADDR_BUF_STATUS, 8'h20);
    chk(tx_irq_flag, 8'h00);
    eng.data_byte(8'h69);
    rdc(ISF_ADDR_RX_BUF, 8'h69);
    chk(clock_stretch, 8'h01);
    chk(module_irq, 8'h01);
    wr(ISF_ADDR_EVT_FLAGS, 8'h00);
    wr(ISF_ADDR_CTRL, 8'h00);
    wr(ISF_ADDR_EVT_EN, 8'h40);
    eng.set_lvl(1'b1, 1'b0);
    eng.ninth(1'b1);
    rdc(ISF_ADDR_EVT_FLAGS, 8'h40);
    chk(clock_stretch, 8'h01);
    wr(ISF_ADDR_EVT_FLAGS, 8'h00);
    wr(ISF_ADDR_CTRL, 8'h00);
    eng.ninth(1'b0);
    rdc(ISF_ADDR_EVT_FLAGS, 8'h40);
    chk(clock_stretch, 8'h00);
    wr(ISF_ADDR_EVT_FLAGS, 8'h00);
    eng.addr_byte(1'b1, 1'b0, 1'b1);
    eng.ninth(1'b1);
    rdc(ISF_ADDR_EVT_FLAGS, 8'h08);
    wr(ISF_ADDR_EVT_FLAGS, 8'h00);
    // Mode 10x is host only, so the client flags must stay quiet
    wr(ISF_ADDR_CTRL, 8'h04);
    eng.addr_byte(1'b1, 1'b1, 1'b0);
    eng.data_byte(8'h11);
    eng.ninth(1'b1);
    rdc(ISF_ADDR_EVT_FLAGS, 8'h00);
    rdc(ISF_ADDR_RX_BUF, 8'h11);
    // Mode 11x is client capable again
    wr(ISF_ADDR_CTRL, 8'h06);
    eng.data_byte(8'h22);
    rdc(ISF_ADDR_EVT_FLAGS, 8'h10);
    wr(ISF_ADDR_EVT_FLAGS, 8'h00);
    wr(ISF_ADDR_CTRL, 8'h00);
    wr(ISF_ADDR_EVT_EN, 8'h00);
    eng.set_lvl(1'b0, 1'b1);
    eng.ninth(1'b1);
    rdc(ISF_ADDR_EVT_FLAGS, 8'h80);
    chk(module_irq, 8'h00);
    wr(ISF_ADDR_EVT_EN, 8'h80);
    rdc(ISF_ADDR_EVT_EN, 8'h80);
    chk(module_irq, 8'h01);
    wr(ISF_ADDR_EVT_EN, 8'h00);
    wr(ISF_ADDR_EVT_FLAGS, 8'h00);
    eng.set_lvl(1'b0, 1'b0);
    for (int i = 0; i < 3; i++) begin
      eng.cond(i);
      rdc(ISF_ADDR_EVT_FLAGS, isf_byte_t'((2 << i) - 1));
      chk(module_irq, 8'h00);
      wr(ISF_ADDR_EVT_EN, isf_byte_t'(1 << i));
      rdc(ISF_ADDR_EVT_EN, isf_byte_t'(1 << i));
      chk(module_irq, 8'h01);
      wr(ISF_ADDR_EVT_EN, 8'h00);
    end
    wr(ISF_ADDR_EVT_FLAGS, 8'h06);
    rdc(ISF_ADDR_EVT_FLAGS, 8'h06);
    wr(ISF_ADDR_EVT_FLAGS, 8'hFF);
    rdc(ISF_ADDR_EVT_FLAGS, ISF_EVT_MASK);
    wr(ISF_ADDR_EVT_EN, 8'hFF);
    rdc(ISF_ADDR_EVT_EN, ISF_EVT_MASK);
    chk(module_irq, 8'h01);
    // A reset in mid-run must bring state and outputs back to idle
    @(posedge clk);
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    rdc(ISF_ADDR_EVT_FLAGS, ISF_FLAGS_RST);
    chk(module_irq, 8'h00);
    chk(tx_data, ISF_BYTE_RST);
    rdc(ISF_ADDR_BUF_STATUS, 8'h20);
    rdc(ISF_ADDR_XFER_STATUS, 8'h00);
    wr(12'h2A0, 8'hFF);
    rdc(12'h2A0, 8'h00);
    complete_run();
  end
endmodule
